// ---- logic/timer_counter_map.svh ----
// Notes on behaviour
// RQ1: Tick from clock select: div 2/4/8 or external
// RQ2: 16-bit up counter, high and low bytes
// RQ3: Main and alternate views read identical count
// RQ4: Low byte write forces counter to FFFCh
// RQ5: Reset and only reload value is FFFCh
// RQ6: High read buffers low byte for later
// RQ7: Buffer frozen until low byte read
// RQ8: Lone low read returns live low byte
// RQ9: Wrap FFFFh to 0000h sets overflow flag
// RQ10: Interrupt needs enable set, CPU mask clear
// RQ11: Clear: status read with flag, then low access
// RQ12: Alternate low access never touches overflow flag
// RQ13: Counter keeps counting in wait mode
// RQ14: Halt freezes counter; reset restarts FFFCh
// RQ15: External clock at least four times slower
// RQ16: Unbonded timer input reads as one
// RQ17: Instances share nothing, count in step
// RQ18: External clock only when select is 11
// RQ19: Edge select bit picks rising or falling
// RQ20: External edges resynchronised, four clocks apart
// RQ21: Select 00/01/10 means divide 4/2/8
`ifndef TIMER_COUNTER_MAP_SVH
`define TIMER_COUNTER_MAP_SVH
`define TCM_ADDR_CHR_HI   8'h00
`define TCM_ADDR_CNT_LO   8'h04
`define TCM_ADDR_ALT_HI   8'h08
`define TCM_ADDR_ALT_LO   8'h0C
`define TCM_ADDR_STATUS   8'h10
`define TCM_ADDR_CTRL1    8'h14
`define TCM_ADDR_CTRL2    8'h18
`define TCM_RELOAD        16'hFFFC
`define TCM_STATUS_OVF    5
`define TCM_CTRL1_OVFIE   5
`define TCM_CTRL2_CSEL_LO 2
`define TCM_CTRL2_CSEL_HI 3
`define TCM_CTRL2_EDGE    0
`define TCM_CSEL_DIV4     2'h0
`define TCM_CSEL_DIV2     2'h1
`define TCM_CSEL_DIV8     2'h2
`define TCM_CSEL_EXT      2'h3
`define TCM_RESP_OKAY     2'h0
`define TCM_RESP_SLVERR   2'h2
`endif

// ---- logic/timer_counter_pkg.sv ----
package timer_counter_pkg;
    typedef enum logic [1:0] {
        RD_IDLE,
        RD_RESP
    } rdState_t;
    typedef enum logic [1:0] {
        WR_IDLE,
        WR_RESP
    } wrState_t;
endpackage

// ---- logic/timer_free_running_counter.sv ----
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "timer_counter_map.svh"
module timer_free_running_counter (
    input  wire logic        clk_sys,        // System clock, 250 MHz
    input  wire logic        rst_n,          // Async reset, active low
    input  wire logic [7:0]  s_axi_awaddr,   // Write address
    input  wire logic        s_axi_awvalid,  // Write address valid
    output logic             s_axi_awready,  // Write address ready
    input  wire logic [31:0] s_axi_wdata,    // Write data
    input  wire logic [3:0]  s_axi_wstrb,    // Write strobes
    input  wire logic        s_axi_wvalid,   // Write data valid
    output logic             s_axi_wready,   // Write data ready
    output logic [1:0]       s_axi_bresp,    // Write response
    output logic             s_axi_bvalid,   // Write response valid
    input  wire logic        s_axi_bready,   // Write response ready
    input  wire logic [7:0]  s_axi_araddr,   // Read address
    input  wire logic        s_axi_arvalid,  // Read address valid
    output logic             s_axi_arready,  // Read address ready
    output logic [31:0]      s_axi_rdata,    // Read data
    output logic [1:0]       s_axi_rresp,    // Read response
    output logic             s_axi_rvalid,   // Read data valid
    input  wire logic        s_axi_rready,   // Read data ready
    input  wire logic        extClkPin,      // External timer clock pin
    input  wire logic        extClkBonded,   // High when the pin is bonded out
    input  wire logic        cpuIrqMask,     // CPU interrupt mask bit
    input  wire logic        haltMode,       // Halt low-power mode active
    input  wire logic        waitMode,       // Wait low-power mode active
    output logic             timerIrq,       // Overflow interrupt request
    output logic [15:0]      countValue      // Counter value for other timer units
);
    logic        rstSync1_q;
    logic        rstSync2_q;
    logic        rstIn_n;
    logic [15:0] count_q;
    logic [7:0]  loBuf_q;
    logic        seqOpen_q;
    logic        ovf_q;
    logic        ovfArmed_q;
    logic        ovfIe_q;
    logic [7:0]  ctrl1_q;
    logic [7:0]  ctrl2_q;
    logic [2:0]  presc_q;
    logic        extSync1_q;
    logic        extSync2_q;
    logic        extPrev_q;
    logic        extInput;
    logic        tick;
    logic        intTick;
    logic        extTick;
    logic [1:0]  csel;
    logic        wrFire;
    logic        rdFire;
    logic [7:0]  awAddr_q;
    logic [31:0] wData_q;
    logic [3:0]  wStrb_q;
    logic        awHave_q;
    logic        wHave_q;
    logic [7:0]  rdAddr;
    logic        loAccessMain;
    logic        loAccessAlt;
    logic        loWrite;
    logic        statusRead;
    logic [31:0] rdData;
    logic        rdErr;
    timer_counter_pkg::rdState_t rdState_q;
    timer_counter_pkg::wrState_t wrState_q;

    // Reset release through two flops
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rstSync1_q <= 1'b0;
            rstSync2_q <= 1'b0;
        end
        else
        begin
            rstSync1_q <= 1'b1;
            rstSync2_q <= rstSync1_q;
        end
    end
    assign rstIn_n = rstSync2_q;

    // Select-field decode, used by prescaler and assertions
    function automatic logic divTap(input logic [1:0] sel, input logic [2:0] pr);
        case (sel)
            `TCM_CSEL_DIV2: divTap = (pr[0] == 1'b1);
            `TCM_CSEL_DIV4: divTap = (pr[1:0] == 2'h3);
            `TCM_CSEL_DIV8: divTap = (pr == 3'h7);
            default:        divTap = 1'b0;
        endcase
    endfunction

    assign csel = ctrl2_q[`TCM_CTRL2_CSEL_HI:`TCM_CTRL2_CSEL_LO];

    // Internal prescaler, stopped in halt; wait has no effect
    // RQ13 wait ignored, RQ14 halt freeze
    always_ff @(posedge clk_sys or negedge rstIn_n)
    begin
        if (!rstIn_n)
            presc_q <= 3'h0;
        else if (!haltMode)
            presc_q <= presc_q + 3'h1;
    end

    // RQ21 select encoding
    assign intTick = (csel != `TCM_CSEL_EXT) && divTap(csel, presc_q);

    // RQ16 unbonded input reads one
    assign extInput = extClkBonded ? extClkPin : 1'b1;

    // External clock resynchroniser and edge memory
    // RQ20 edge synchronisation
    always_ff @(posedge clk_sys or negedge rstIn_n)
    begin
        if (!rstIn_n)
        begin
            extSync1_q <= 1'b1;
            extSync2_q <= 1'b1;
            extPrev_q  <= 1'b1;
        end
        else
        begin
            extSync1_q <= extInput;
            extSync2_q <= extSync1_q;
            extPrev_q  <= extSync2_q;
        end
    end

    // RQ19 edge select, RQ18 external only on 11
    assign extTick = (csel == `TCM_CSEL_EXT) &&
                     (ctrl2_q[`TCM_CTRL2_EDGE] ? (extSync2_q && !extPrev_q)
                                               : (!extSync2_q && extPrev_q));

    // RQ1 tick source
    assign tick = !haltMode && (intTick || extTick);

    // Bus side effect decode
    assign wrFire       = (wrState_q == timer_counter_pkg::WR_IDLE) && awHave_q && wHave_q;
    assign rdFire       = s_axi_arvalid && s_axi_arready;
    assign rdAddr       = {s_axi_araddr[7:2], 2'b00};
    assign loWrite      = wrFire && (awAddr_q == `TCM_ADDR_CNT_LO || awAddr_q == `TCM_ADDR_ALT_LO)
                          && wStrb_q[0];
    assign loAccessMain = (rdFire && rdAddr == `TCM_ADDR_CNT_LO) ||
                          (wrFire && awAddr_q == `TCM_ADDR_CNT_LO);
    assign loAccessAlt  = (rdFire && rdAddr == `TCM_ADDR_ALT_LO) ||
                          (wrFire && awAddr_q == `TCM_ADDR_ALT_LO);
    assign statusRead   = rdFire && rdAddr == `TCM_ADDR_STATUS;

    // Free-running counter
    // RQ2 up count, RQ4 low write reload, RQ5 only reload value
    // RQ17 no shared state, fixed start
    always_ff @(posedge clk_sys or negedge rstIn_n)
    begin
        if (!rstIn_n)
            count_q <= `TCM_RELOAD;
        else if (loWrite)
            count_q <= `TCM_RELOAD;
        else if (tick)
            count_q <= count_q + 16'h0001;
    end
    assign countValue = count_q;

    // Low byte buffer for high-then-low reads
    // RQ6 capture, RQ7 freeze until low read
    always_ff @(posedge clk_sys or negedge rstIn_n)
    begin
        if (!rstIn_n)
        begin
            seqOpen_q <= 1'b0;
            loBuf_q   <= 8'h00;
        end
        else if (rdFire && (rdAddr == `TCM_ADDR_CHR_HI || rdAddr == `TCM_ADDR_ALT_HI))
        begin
            if (!seqOpen_q)
                loBuf_q <= count_q[7:0];
            seqOpen_q <= 1'b1;
        end
        else if (rdFire && (rdAddr == `TCM_ADDR_CNT_LO || rdAddr == `TCM_ADDR_ALT_LO))
            seqOpen_q <= 1'b0;
    end

    // Overflow flag with two-step clear; a wrap wins over clear
    // RQ9 set on wrap, RQ11 two-step clear, RQ12 alternate ignored
    always_ff @(posedge clk_sys or negedge rstIn_n)
    begin
        if (!rstIn_n)
        begin
            ovf_q      <= 1'b0;
            ovfArmed_q <= 1'b0;
        end
        else
        begin
            if (tick && !loWrite && count_q == 16'hFFFF)
                ovf_q <= 1'b1;
            else if (loAccessMain && ovfArmed_q)
                ovf_q <= 1'b0;
            if (statusRead && ovf_q)
                ovfArmed_q <= 1'b1;
            else if (loAccessMain)
                ovfArmed_q <= 1'b0;
        end
    end

    // RQ10 gated interrupt request
    assign ovfIe_q  = ctrl1_q[`TCM_CTRL1_OVFIE];
    assign timerIrq = ovf_q && ovfIe_q && !cpuIrqMask;

    // Control registers
    always_ff @(posedge clk_sys or negedge rstIn_n)
    begin
        if (!rstIn_n)
        begin
            ctrl1_q <= 8'h00;
            ctrl2_q <= 8'h00;
        end
        else if (wrFire && wStrb_q[0])
        begin
            if (awAddr_q == `TCM_ADDR_CTRL1)
                ctrl1_q <= wData_q[7:0];
            if (awAddr_q == `TCM_ADDR_CTRL2)
                ctrl2_q <= wData_q[7:0];
        end
    end

    // Write channel: hold address and data, accept in either order
    always_ff @(posedge clk_sys or negedge rstIn_n)
    begin
        if (!rstIn_n)
        begin
            awHave_q  <= 1'b0;
            wHave_q   <= 1'b0;
            awAddr_q  <= 8'h00;
            wData_q   <= 32'h00000000;
            wStrb_q   <= 4'h0;
            wrState_q <= timer_counter_pkg::WR_IDLE;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHave_q <= 1'b1;
                awAddr_q <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHave_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            case (wrState_q)
                timer_counter_pkg::WR_IDLE:
                    if (wrFire)
                    begin
                        awHave_q  <= 1'b0;
                        wHave_q   <= 1'b0;
                        wrState_q <= timer_counter_pkg::WR_RESP;
                    end
                timer_counter_pkg::WR_RESP:
                    if (s_axi_bready)
                        wrState_q <= timer_counter_pkg::WR_IDLE;
                default:
                    wrState_q <= timer_counter_pkg::WR_IDLE;
            endcase
        end
    end

    assign s_axi_awready = !awHave_q && (wrState_q == timer_counter_pkg::WR_IDLE);
    assign s_axi_wready  = !wHave_q && (wrState_q == timer_counter_pkg::WR_IDLE);
    assign s_axi_bvalid  = (wrState_q == timer_counter_pkg::WR_RESP);

    // Write response kept from the decoded address
    always_ff @(posedge clk_sys or negedge rstIn_n)
    begin
        if (!rstIn_n)
            s_axi_bresp <= `TCM_RESP_OKAY;
        else if (wrFire)
            s_axi_bresp <= (awAddr_q == `TCM_ADDR_CNT_LO || awAddr_q == `TCM_ADDR_ALT_LO ||
                            awAddr_q == `TCM_ADDR_CTRL1 || awAddr_q == `TCM_ADDR_CTRL2)
                           ? `TCM_RESP_OKAY : `TCM_RESP_SLVERR;
    end

    // Read mux
    // RQ3 identical views, RQ8 live low byte
    always_comb
    begin
        rdData = 32'h00000000;
        rdErr  = 1'b0;
        case ({rdAddr[7:2], 2'b00})
            `TCM_ADDR_CHR_HI,
            `TCM_ADDR_ALT_HI: rdData[7:0] = count_q[15:8];
            `TCM_ADDR_CNT_LO,
            `TCM_ADDR_ALT_LO: rdData[7:0] = seqOpen_q ? loBuf_q : count_q[7:0];
            `TCM_ADDR_STATUS: rdData[`TCM_STATUS_OVF] = ovf_q;
            `TCM_ADDR_CTRL1:  rdData[7:0] = ctrl1_q;
            `TCM_ADDR_CTRL2:  rdData[7:0] = ctrl2_q;
            default:          rdErr = 1'b1;
        endcase
    end

    // Read channel: one read at a time, data registered
    always_ff @(posedge clk_sys or negedge rstIn_n)
    begin
        if (!rstIn_n)
        begin
            rdState_q   <= timer_counter_pkg::RD_IDLE;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `TCM_RESP_OKAY;
        end
        else
        begin
            case (rdState_q)
                timer_counter_pkg::RD_IDLE:
                    if (rdFire)
                    begin
                        s_axi_rdata <= rdData;
                        s_axi_rresp <= rdErr ? `TCM_RESP_SLVERR : `TCM_RESP_OKAY;
                        rdState_q   <= timer_counter_pkg::RD_RESP;
                    end
                timer_counter_pkg::RD_RESP:
                    if (s_axi_rready)
                        rdState_q <= timer_counter_pkg::RD_IDLE;
                default:
                    rdState_q <= timer_counter_pkg::RD_IDLE;
            endcase
        end
    end
    assign s_axi_arready = (rdState_q == timer_counter_pkg::RD_IDLE);
    assign s_axi_rvalid  = (rdState_q == timer_counter_pkg::RD_RESP);

    // Checks
    // Second clear step on an armed flag, with no wrap in the same cycle
    sequence armStep;
        ovfArmed_q && loAccessMain && !(tick && !loWrite && count_q == 16'hFFFF);
    endsequence
    sequence clearedStep;
        !ovf_q;
    endsequence

    a_two_step_clear: assert property (@(posedge clk_sys) disable iff (!rstIn_n) // RQ11
        armStep |=> clearedStep)
        else $error("Overflow flag not cleared by armed low access");
    a_wait_counts: assert property (@(posedge clk_sys) disable iff (!rstIn_n) // RQ13
        (waitMode && !haltMode && intTick) |-> tick)
        else $error("Wait mode blocked a timer tick");

    a_reload_on_write: assert property (@(posedge clk_sys) disable iff (!rstIn_n) // RQ4
        loWrite |=> count_q == `TCM_RELOAD)
        else $error("Counter not reloaded after low write");
    a_count_step: assert property (@(posedge clk_sys) disable iff (!rstIn_n) // RQ2
        (tick && !loWrite) |=> count_q == $past(count_q) + 16'h0001)
        else $error("Counter did not step on tick");
    a_halt_freeze: assert property (@(posedge clk_sys) disable iff (!rstIn_n) // RQ14
        (haltMode && !loWrite) |=> $stable(count_q))
        else $error("Counter moved in halt");
    a_wrap_sets_flag: assert property (@(posedge clk_sys) disable iff (!rstIn_n) // RQ9
        (tick && !loWrite && count_q == 16'hFFFF) |=> ovf_q && count_q == 16'h0000)
        else $error("Wrap did not set overflow flag");
    a_alt_keeps_flag: assert property (@(posedge clk_sys) disable iff (!rstIn_n) // RQ12
        (ovf_q && loAccessAlt && !loAccessMain) |=> ovf_q)
        else $error("Alternate low access cleared overflow flag");
    a_irq_gating: assert property (@(posedge clk_sys) disable iff (!rstIn_n) // RQ10
        timerIrq == (ovf_q && ctrl1_q[`TCM_CTRL1_OVFIE] && !cpuIrqMask))
        else $error("Interrupt request gating wrong");
    a_buffer_frozen: assert property (@(posedge clk_sys) disable iff (!rstIn_n) // RQ7
        (seqOpen_q && !(rdFire && rdAddr == `TCM_ADDR_CNT_LO)
                   && !(rdFire && rdAddr == `TCM_ADDR_ALT_LO)) |=> $stable(loBuf_q) && seqOpen_q)
        else $error("Low byte buffer changed in open sequence");
    a_div2_rate: assert property (@(posedge clk_sys) disable iff (!rstIn_n) // RQ21
        (csel == `TCM_CSEL_DIV2 && !haltMode && intTick) |=> !intTick)
        else $error("Divide by two ticked twice in a row");
    a_ext_needs_sel: assert property (@(posedge clk_sys) disable iff (!rstIn_n) // RQ18
        extTick |-> csel == `TCM_CSEL_EXT && !intTick)
        else $error("External tick with internal selection");
endmodule

// ---- dv/timer_free_running_counter_tb_top.sv ----
`timescale 1ns/1ns
`include "timer_counter_map.svh"
module timer_free_running_counter_tb_top;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  awAddr = 8'h00, arAddr = 8'h00;
    logic        awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
    logic        arValid = 1'b0, rReady = 1'b0;
    logic [31:0] wData = 32'h0;
    logic        awReady, wReady, bValid, arReady, rValid, timerIrq;
    logic [1:0]  bResp, rResp;
    logic [31:0] rData;
    logic [15:0] countValue;
    logic        extClkPin = 1'b0, extClkBonded = 1'b1;
    logic        cpuIrqMask = 1'b0, haltMode = 1'b1, waitMode = 1'b0;
    int          fail_count = 0;
    int          compares = 0;
    logic [31:0] rd;
    logic [1:0]  rs;
    logic [15:0] cv0;

    timer_free_running_counter u_dut (
        .clk_sys(clk_sys), .rst_n(rst_n),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
        .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady), .extClkPin(extClkPin),
        .extClkBonded(extClkBonded), .cpuIrqMask(cpuIrqMask), .haltMode(haltMode),
        .waitMode(waitMode), .timerIrq(timerIrq), .countValue(countValue)
    );

    // Free-running 250 MHz clock
    always #2 clk_sys = ~clk_sys;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Write with address and data offered together, each released when taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit awDone, wDone;
        awDone = 0;
        wDone = 0;
        @(posedge clk_sys);
        awAddr <= a; wData <= d; awValid <= 1'b1; wValid <= 1'b1; bReady <= 1'b1;
        while (!(awDone && wDone))
        begin
            @(posedge clk_sys);
            if (!awDone && awReady === 1'b1)
            begin
                awDone = 1;
                awValid <= 1'b0;
            end
            if (!wDone && wReady === 1'b1)
            begin
                wDone = 1;
                wValid <= 1'b0;
            end
        end
        do @(posedge clk_sys); while (bValid !== 1'b1);
        r = bResp;
        bReady <= 1'b0;
    endtask

    // Read with rready held from the start until rvalid is sampled
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        arAddr <= a; arValid <= 1'b1; rReady <= 1'b1;
        do @(posedge clk_sys); while (arReady !== 1'b1);
        arValid <= 1'b0;
        do @(posedge clk_sys); while (rValid !== 1'b1);
        d = rData;
        r = rResp;
        rReady <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        axi_read(a, rd, rs);
        check(rd, exp);
        check({30'h0, rs}, {30'h0, `TCM_RESP_OKAY});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        axi_write(a, d, rs);
    endtask

    // Full pin pulses, well over four clocks per level
    // pin slower than four clocks
    task automatic ext_pulses(input int n);
        repeat (n)
        begin
            @(posedge clk_sys) extClkPin <= 1'b1;
            repeat (6) @(posedge clk_sys);
            extClkPin <= 1'b0;
            repeat (6) @(posedge clk_sys);
        end
        repeat (6) @(posedge clk_sys);
    endtask

    // Reset state while halted keeps the count frozen
    task automatic reset_test();
        check(countValue, 16'hFFFC);
        rd_chk(`TCM_ADDR_STATUS, 32'h0);
        rd_chk(`TCM_ADDR_CTRL1, 32'h0);
        rd_chk(`TCM_ADDR_CTRL2, 32'h0);
        $display("reset_test done");
    endtask

    // Tick spacing for each internal divider, wait mode on for one of them
    task automatic prescale_test();
        logic [1:0] sel[3] = '{`TCM_CSEL_DIV4, `TCM_CSEL_DIV2, `TCM_CSEL_DIV8};
        int div[3] = '{4, 2, 8};
        int n;
        haltMode <= 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            waitMode <= (i == 1);
            wr(`TCM_ADDR_CTRL2, {28'h0, sel[i], 2'b00});
            cv0 = countValue;
            do @(posedge clk_sys); while (countValue === cv0);
            cv0 = countValue;
            n = 0;
            do
            begin
                @(posedge clk_sys);
                n++;
            end
            while (countValue === cv0 && n < 20);
            check(n, div[i]);
            check(countValue, 16'(cv0 + 16'h1));
        end
        waitMode <= 1'b0;
        $display("prescale_test done");
    endtask

    // External clock: rising, falling and unbonded pin
    task automatic ext_test();
        wr(`TCM_ADDR_CTRL2, 32'h0D);
        cv0 = countValue;
        ext_pulses(5);
        check(countValue, 16'(cv0 + 16'd5));
        wr(`TCM_ADDR_CTRL2, 32'h0C);
        cv0 = countValue;
        ext_pulses(3);
        check(countValue, 16'(cv0 + 16'd3));
        wr(`TCM_ADDR_CTRL2, 32'h0D);
        @(posedge clk_sys) extClkPin <= 1'b1;
        repeat (8) @(posedge clk_sys);
        extClkBonded <= 1'b0;
        repeat (8) @(posedge clk_sys);
        cv0 = countValue;
        ext_pulses(3);
        check(countValue, cv0);
        extClkBonded <= 1'b1;
        repeat (8) @(posedge clk_sys);
        $display("ext_test done");
    endtask

    // Halt freezes and counting resumes from the held value
    task automatic halt_test();
        haltMode <= 1'b1;
        cv0 = countValue;
        ext_pulses(3);
        check(countValue, cv0);
        haltMode <= 1'b0;
        ext_pulses(2);
        check(countValue, 16'(cv0 + 16'd2));
        $display("halt_test done");
    endtask

    // Buffered high-then-low reads on both views
    task automatic read_seq_test();
        wr(`TCM_ADDR_CNT_LO, 32'h0);
        check(countValue, `TCM_RELOAD);
        rd_chk(`TCM_ADDR_CHR_HI, 32'hFF);
        ext_pulses(2);
        rd_chk(`TCM_ADDR_CHR_HI, 32'hFF);
        rd_chk(`TCM_ADDR_CNT_LO, 32'hFC);
        rd_chk(`TCM_ADDR_CNT_LO, 32'hFE);
        rd_chk(`TCM_ADDR_ALT_HI, 32'hFF);
        ext_pulses(1);
        rd_chk(`TCM_ADDR_ALT_LO, 32'hFE);
        rd_chk(`TCM_ADDR_ALT_LO, 32'hFF);
        check(countValue, 16'hFFFF);
        ext_pulses(1);
        wr(`TCM_ADDR_ALT_LO, 32'h0);
        check(countValue, `TCM_RELOAD);
        $display("read_seq_test done");
    endtask

    // Overflow flag, interrupt gating and the two-step clear
    task automatic overflow_test();
        rd_chk(`TCM_ADDR_STATUS, 32'h20);
        rd_chk(`TCM_ADDR_CNT_LO, 32'hFC);
        rd_chk(`TCM_ADDR_STATUS, 32'h0);
        ext_pulses(3);
        check(countValue, 16'hFFFF);
        rd_chk(`TCM_ADDR_STATUS, 32'h0);
        ext_pulses(1);
        check(countValue, 16'h0000);
        check(timerIrq, 1'b0);
        wr(`TCM_ADDR_CTRL1, 32'h20);
        rd_chk(`TCM_ADDR_CTRL1, 32'h20);
        check(timerIrq, 1'b1);
        @(posedge clk_sys) cpuIrqMask <= 1'b1;
        repeat (2) @(posedge clk_sys);
        check(timerIrq, 1'b0);
        @(posedge clk_sys) cpuIrqMask <= 1'b0;
        rd_chk(`TCM_ADDR_CNT_LO, 32'h00);
        rd_chk(`TCM_ADDR_STATUS, 32'h20);
        rd_chk(`TCM_ADDR_ALT_LO, 32'h00);
        rd_chk(`TCM_ADDR_STATUS, 32'h20);
        rd_chk(`TCM_ADDR_CNT_LO, 32'h00);
        rd_chk(`TCM_ADDR_STATUS, 32'h00);
        check(timerIrq, 1'b0);
        $display("overflow_test done");
    endtask

    // Unmapped address answers with an error and zero data
    task automatic bus_test();
        axi_read(8'h1C, rd, rs);
        check(rd, 32'h0);
        check({30'h0, rs}, {30'h0, `TCM_RESP_SLVERR});
        axi_write(8'h1C, 32'h5A, rs);
        check({30'h0, rs}, {30'h0, `TCM_RESP_SLVERR});
        $display("bus_test done");
    endtask

    // Watchdog cuts a hang short
    initial
    begin
        #200000;
        fail_count++;
        $display("Watchdog expired");
        finish_test();
    end

    // Main sequence
    initial
    begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        reset_test();
        prescale_test();
        ext_test();
        halt_test();
        read_seq_test();
        overflow_test();
        bus_test();
        finish_test();
    end
endmodule
